/* rtl/pac_cfg.svh */
// Shared constants for the pipelined converter control block.
`ifndef PAC_CFG_SVH
`define PAC_CFG_SVH

// Datapath sizes.
`define PAC_RES_W 12
`define PAC_STAGES 15
`define PAC_COEF_W 14
`define PAC_IDX_W 4

// Sequence lengths, in conversion clock periods.
`define PAC_CAL_CYCLES 4000
`define PAC_PD_EXIT_CYCLES 4000
`define PAC_REQ_MIN_CYCLES 3
`define PAC_LATENCY 10

// Register offsets on the local register port.
`define PAC_ADDR_W 4
`define PAC_OFF_STATUS 4'h0
`define PAC_OFF_MASK 4'h4
`define PAC_OFF_STATE 4'h8
`define PAC_OFF_CTRL 4'hC

// Status and mask bit positions.
`define PAC_EV_CAL_DONE 0
`define PAC_EV_PDX_DONE 1
`define PAC_EV_PD_ENTER 2
`define PAC_EV_W 3

// Control register bit positions.
`define PAC_CTRL_CAL 0

// Reset values.
`define PAC_MASK_RST 3'h0

`endif

/* rtl/pac_pkg.sv */
// Types shared by the converter control block.
package pac_pkg;

  // Operating phases of the converter.
  typedef enum logic [1:0] {
    PAC_CAL,
    PAC_RUN,
    PAC_PD,
    PAC_PDX
  } pac_state_e;

endpackage : pac_pkg

/* rtl/pac_corr_if.sv */
// Link between the sequencer and the digital correction engine.
`timescale 1ns/1ps
`default_nettype none
`include "pac_cfg.svh"

interface pac_corr_if;
  logic coef_we;
  logic [`PAC_IDX_W-1:0] coef_idx;
  logic [`PAC_COEF_W-1:0] coef_data;
  logic [`PAC_STAGES-1:0] raw_bits;
  logic [`PAC_RES_W-1:0] corrected;

  modport ctrl (
    output coef_we,
    output coef_idx,
    output coef_data,
    output raw_bits,
    input corrected
  );

  modport corr (
    input coef_we,
    input coef_idx,
    input coef_data,
    input raw_bits,
    output corrected
  );
endinterface : pac_corr_if

`default_nettype wire

/* rtl/pac_corrector.sv */
// Correction engine: stage weights in a small memory, summed into the output code.
`timescale 1ns/1ps
`default_nettype none
`include "pac_cfg.svh"

module pac_corrector
  import pac_pkg::*;
#(
  parameter int STAGES = `PAC_STAGES,
  parameter int COEF_W = `PAC_COEF_W,
  parameter int RES_W = `PAC_RES_W
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  pac_corr_if.corr corr_io
);

  localparam int ACC_W = COEF_W + 4;

  logic [COEF_W-1:0] coef_q [STAGES];
  logic [ACC_W-1:0] acc;
  logic [RES_W-1:0] code_q;

  // Coefficients are written one stage at a time while calibration runs.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < STAGES; i++) begin
        coef_q[i] <= '0;
      end
    end else if (corr_io.coef_we && (int'(corr_io.coef_idx) < STAGES)) begin
      coef_q[corr_io.coef_idx] <= corr_io.coef_data;
    end
  end

  // Each raw stage bit that is set adds its measured weight.
  always_comb begin
    acc = '0;
    for (int i = 0; i < STAGES; i++) begin
      if (corr_io.raw_bits[i]) begin
        acc = acc + ACC_W'(coef_q[i]);
      end
    end
  end

  // Saturate rather than wrap, so a large raw error cannot fold to a low code.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      code_q <= '0;
    end else if (acc[ACC_W-1:RES_W] != '0) begin
      code_q <= '1;
    end else begin
      code_q <= acc[RES_W-1:0];
    end
  end

  assign corr_io.corrected = code_q;

endmodule : pac_corrector

`default_nettype wire

/* rtl/pac_control.sv */
// Control and timing of a 12-bit pipelined converter: calibration, power-down, output port.
// Contract
// - Result outputs change only just after a rising clock edge and the host samples after that.
// - With the output enable high the result pins float; with it low they are driven.
// - Ready falls within 3 clock periods after a valid calibration request.
// - Power-down held at least 3 periods enters low power and ready falls within 3 periods.
// - Releasing power-down starts a 4000 period exit sequence that ends with ready high.
// - Calibration runs at power-on and on request, storing weights used for every code.
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pac_cfg.svh"

module pac_control
  import pac_pkg::*;
#(
  parameter int CAL_CYCLES = `PAC_CAL_CYCLES,
  parameter int PD_EXIT_CYCLES = `PAC_PD_EXIT_CYCLES,
  parameter int REQ_MIN = `PAC_REQ_MIN_CYCLES,
  parameter int LATENCY = `PAC_LATENCY
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic cal_request_in,
  input wire logic power_down_request_in,
  input wire logic out_enable_n_in,
  input wire logic [`PAC_STAGES-1:0] raw_bits_in,
  input wire logic [`PAC_COEF_W-1:0] cal_weight_in,
  input wire logic [`PAC_ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [31:0] reg_rdata_out,
  output logic [`PAC_RES_W-1:0] conversion_result_out,
  output logic conversion_result_oe_n_out,
  output logic ready_out,
  output logic low_power_out,
  output logic irq_out
);

  localparam int CNT_W = 12;
  localparam int RUN_W = 2;
  // The corrector register, this line and the output flop span LATENCY edges from sampling.
  localparam int DLY = LATENCY - 1;

  pac_corr_if corr_if ();

  pac_state_e state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [1:0] cal_sync_q, pd_sync_q, oe_sync_q;
  logic [RUN_W-1:0] cal_run_q, pd_run_q;
  logic cal_valid, pd_valid, sw_cal, cal_start;
  logic [`PAC_EV_W-1:0] status_q, mask_q, events;
  logic [`PAC_RES_W-1:0] dly_q [DLY];

  // True when a strobe targets the given register offset.
  function automatic logic reg_hit(input logic [`PAC_ADDR_W-1:0] addr,
                                   input logic [`PAC_ADDR_W-1:0] off);
    reg_hit = (addr == off);
  endfunction : reg_hit

  pac_corrector u_corrector (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .corr_io(corr_if.corr)
  );

  // Pins come from the host's domain; bit 0 is only ever read by bit 1.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cal_sync_q <= 2'h0;
      pd_sync_q <= 2'h0;
      oe_sync_q <= 2'h3;
    end else begin
      cal_sync_q <= {cal_sync_q[0], cal_request_in};
      pd_sync_q <= {pd_sync_q[0], power_down_request_in};
      oe_sync_q <= {oe_sync_q[0], out_enable_n_in};
    end
  end

  // Width filters count consecutive high samples, saturating at the minimum.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cal_run_q <= '0;
      pd_run_q <= '0;
    end else begin
      if (!cal_sync_q[1]) begin
        cal_run_q <= '0;
      end else if (cal_run_q != RUN_W'(REQ_MIN)) begin
        cal_run_q <= cal_run_q + 2'h1;
      end
      if (!pd_sync_q[1]) begin
        pd_run_q <= '0;
      end else if (pd_run_q != RUN_W'(REQ_MIN)) begin
        pd_run_q <= pd_run_q + 2'h1;
      end
    end
  end

  // Short high pulses never raise a request; a request fires once per hold.
  assign cal_valid = cal_sync_q[1] && (cal_run_q == RUN_W'(REQ_MIN - 1));
  assign pd_valid = pd_sync_q[1] && (pd_run_q == RUN_W'(REQ_MIN - 1));
  assign sw_cal = reg_write_in && reg_hit(reg_addr_in, `PAC_OFF_CTRL)
                  && reg_wdata_in[`PAC_CTRL_CAL];
  assign cal_start = cal_valid || sw_cal;

  // Sequencer; power-down outranks calibration since it must cut power promptly.
  always_comb begin
    state_d = state_q;
    case (state_q)
      PAC_RUN: begin
        if (pd_valid) begin
          state_d = PAC_PD;
        end else if (cal_start) begin
          state_d = PAC_CAL;
        end
      end
      PAC_CAL: begin
        if (pd_valid) begin
          state_d = PAC_PD;
        end else if (cnt_q == CNT_W'(CAL_CYCLES - 1)) begin
          state_d = PAC_RUN;
        end
      end
      PAC_PD: begin
        if (!pd_sync_q[1]) begin
          state_d = PAC_PDX;
        end
      end
      PAC_PDX: begin
        if (pd_valid) begin
          state_d = PAC_PD;
        end else if (cnt_q == CNT_W'(PD_EXIT_CYCLES - 1)) begin
          state_d = PAC_RUN;
        end
      end
      default: begin
        state_d = PAC_CAL;
      end
    endcase
  end

  assign cnt_d = (state_d != state_q) ? '0 : cnt_q + 12'h001;

  // Reset lands in calibration, so power-on always measures fresh weights.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= PAC_CAL;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Ready and low-power follow the next state, so they move one edge after a request.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ready_out <= 1'b0;
      low_power_out <= 1'b0;
    end else begin
      ready_out <= (state_d == PAC_RUN);
      low_power_out <= (state_d == PAC_PD);
    end
  end

  // The first calibration cycles capture one stage weight each.
  assign corr_if.coef_we = (state_q == PAC_CAL) && (cnt_q < CNT_W'(`PAC_STAGES));
  assign corr_if.coef_idx = cnt_q[`PAC_IDX_W-1:0];
  assign corr_if.coef_data = cal_weight_in;
  assign corr_if.raw_bits = raw_bits_in;

  // Delay line pads the correction stage out to the full pipeline latency.
  generate
    for (genvar k = 0; k < DLY; k++) begin : g_dly
      always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          dly_q[k] <= '0;
        end else if (k == 0) begin
          dly_q[k] <= corr_if.corrected;
        end else begin
          dly_q[k] <= dly_q[(k == 0) ? 0 : k - 1];
        end
      end
    end
  endgenerate

  // Results keep streaming while ready is low; the host drops those words.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      conversion_result_out <= '0;
      conversion_result_oe_n_out <= 1'b1;
    end else begin
      conversion_result_out <= dly_q[DLY-1];
      conversion_result_oe_n_out <= oe_sync_q[1];
    end
  end

  // Events raised by the sequencer.
  always_comb begin
    events = '0;
    events[`PAC_EV_CAL_DONE] = (state_q == PAC_CAL) && (state_d == PAC_RUN);
    events[`PAC_EV_PDX_DONE] = (state_q == PAC_PDX) && (state_d == PAC_RUN);
    events[`PAC_EV_PD_ENTER] = (state_q != PAC_PD) && (state_d == PAC_PD);
  end

  // Reading status clears it, but a same-cycle event survives the clear.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      status_q <= '0;
    end else if (reg_read_in && reg_hit(reg_addr_in, `PAC_OFF_STATUS)) begin
      status_q <= events;
    end else begin
      status_q <= status_q | events;
    end
  end

  // Mask register.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mask_q <= `PAC_MASK_RST;
    end else if (reg_write_in && reg_hit(reg_addr_in, `PAC_OFF_MASK)) begin
      mask_q <= reg_wdata_in[`PAC_EV_W-1:0];
    end
  end

  // Interrupt level is registered, so it trails the status by one cycle.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status_q & mask_q);
    end
  end

  // Read data stand for one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (!reg_read_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_hit(reg_addr_in, `PAC_OFF_STATUS)) begin
      reg_rdata_out <= {29'h0, status_q};
    end else if (reg_hit(reg_addr_in, `PAC_OFF_MASK)) begin
      reg_rdata_out <= {29'h0, mask_q};
    end else if (reg_hit(reg_addr_in, `PAC_OFF_STATE)) begin
      reg_rdata_out <= {12'h000, cnt_q, 5'h00, ready_out, state_q};
    end else begin
      reg_rdata_out <= 32'h00000000;
    end
  end

  // Checks on the sequencer and output timing.
  ready_low_cal_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (state_q == PAC_RUN && cal_start && !pd_valid) |-> ##[1:3] !ready_out)
    else $error("ready did not fall after a calibration request");

  ready_low_pd_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    pd_valid |-> ##[1:3] (!ready_out && low_power_out))
    else $error("ready did not fall after a power-down request");

  cal_length_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    ($rose(ready_out) && $past(state_q) == PAC_CAL)
      |-> $past(cnt_q) == CNT_W'(CAL_CYCLES - 1))
    else $error("calibration did not last the full cycle count");

  pd_exit_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (state_q == PAC_PDX && cnt_q == CNT_W'(PD_EXIT_CYCLES - 1) && !pd_valid)
      |=> (state_q == PAC_RUN && ready_out))
    else $error("power-down exit did not end on time");

  pd_hold_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (state_q == PAC_PD && pd_sync_q[1]) |=> (state_q == PAC_PD && !ready_out))
    else $error("left low power while the request was held");

  result_latency_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    $past(arst_n_in, 10) |-> conversion_result_out == $past(corr_if.corrected, 10))
    else $error("result did not appear at the fixed latency");

  oe_follow_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    ($past(arst_n_in, 1) && $past(arst_n_in, 2) && $past(arst_n_in, 3))
      |-> conversion_result_oe_n_out == $past(out_enable_n_in, 3))
    else $error("output enable did not follow the pin");

  cal_done_flag_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (state_q == PAC_CAL && state_d == PAC_RUN) |=> status_q[`PAC_EV_CAL_DONE])
    else $error("calibration end did not set its status bit");

  coef_capture_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (state_q == PAC_CAL && cnt_q == 12'h000) |-> corr_if.coef_we ##1 corr_if.coef_we)
    else $error("calibration did not store stage weights");

  short_req_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (state_q == PAC_RUN && !cal_sync_q[1] && !sw_cal && !pd_valid) |=> state_q == PAC_RUN)
    else $error("calibration started without a held request");

endmodule : pac_control

`default_nettype wire

/* tb/pac_host_model.sv */
// Host-side model: drives the control pins and stage bits and keeps only valid words.
`timescale 1ns/1ps
`default_nettype none
`include "pac_cfg.svh"

module pac_host_model (
  input wire logic clk_in,
  input wire logic ready_in,
  input wire logic [`PAC_RES_W-1:0] word_in,
  output logic cal_out,
  output logic pd_out,
  output logic oe_n_out,
  output logic [`PAC_STAGES-1:0] raw_out,
  output logic [`PAC_COEF_W-1:0] weight_out
);
  logic [`PAC_RES_W-1:0] kept_q;

  // Pins start inactive, with the output enable pin held low from time zero.
  initial begin
    cal_out = 1'b0;
    pd_out = 1'b0;
    oe_n_out = 1'b0;
    raw_out = '0;
    weight_out = 14'h0100;
  end

  // Words that arrive while ready is low are thrown away as invalid.
  always @(posedge clk_in) begin
    if (ready_in) begin
      kept_q <= word_in;
    end
  end

  // A count below three is how the bench shows that brief pulses are refused.
  task automatic pulse_cal(input int n);
    cal_out <= 1'b1;
    repeat (n) @(posedge clk_in);
    cal_out <= 1'b0;
  endtask : pulse_cal

  // The caller holds the level for as long as low power is wanted.
  task automatic set_pd(input logic lvl);
    pd_out <= lvl;
  endtask : set_pd

  // Enable and stage bits are plain levels changed at the caller's edge.
  task automatic set_oe_n(input logic lvl);
    oe_n_out <= lvl;
  endtask : set_oe_n

  task automatic set_raw(input logic [`PAC_STAGES-1:0] bits);
    raw_out <= bits;
  endtask : set_raw

  task automatic set_weight(input logic [`PAC_COEF_W-1:0] w);
    weight_out <= w;
  endtask : set_weight
endmodule : pac_host_model

`default_nettype wire

/* tb/test_pipelined_adc_control_timing.sv */
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`default_nettype none
`include "pac_cfg.svh"

module test_pipelined_adc_control_timing;
  import pac_pkg::*;
  localparam int CAL_N = 40;
  localparam int PDX_N = 40;
  localparam int LAT = `PAC_LATENCY;
  logic clk_in;
  logic arst_n_in;
  logic cal;
  logic pd;
  logic oe_n;
  logic [`PAC_STAGES-1:0] raw;
  logic [`PAC_COEF_W-1:0] weight;
  logic [`PAC_ADDR_W-1:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [`PAC_RES_W-1:0] result;
  logic oe_n_o;
  logic ready;
  logic low_power;
  logic irq;
  wire logic [`PAC_RES_W-1:0] result_pin;
  int mismatches;
  int num_checks;
  int n;
  logic [31:0] v;

  // The result pins float whenever the block lets go of them.
  assign result_pin = oe_n_o ? 12'hZZZ : result;

  // The build clock is faster than the pin range; the sequencer only counts edges.
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  pac_control #(.CAL_CYCLES(CAL_N), .PD_EXIT_CYCLES(PDX_N)) u_pac_control (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .cal_request_in(cal),
    .power_down_request_in(pd), .out_enable_n_in(oe_n), .raw_bits_in(raw),
    .cal_weight_in(weight), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata),
    .conversion_result_out(result), .conversion_result_oe_n_out(oe_n_o),
    .ready_out(ready), .low_power_out(low_power), .irq_out(irq));

  pac_host_model u_pac_host_model (
    .clk_in(clk_in), .ready_in(ready), .word_in(result_pin), .cal_out(cal),
    .pd_out(pd), .oe_n_out(oe_n), .raw_out(raw), .weight_out(weight));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_write(input logic [`PAC_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic reg_read(input logic [`PAC_ADDR_W-1:0] a);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : reg_read

  // Counts edges until ready reaches the level, giving up at the limit.
  task automatic wait_ready(input logic lvl, input int lim);
    n = 0;
    while (ready !== lvl && n < lim) begin
      @(posedge clk_in);
      #1;
      n++;
    end
  endtask : wait_ready

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // A hang is cut off long after the whole sequence should have ended.
  initial begin
    #100000;
    mismatches++;
    results();
  end

  // Main sequence of tests.
  initial begin
    mismatches = 0;
    num_checks = 0;
    arst_n_in = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    check("oe_n in reset", 32'(oe_n_o), 32'h1);
    check("ready in reset", 32'(ready), 32'h0);
    @(posedge clk_in);
    arst_n_in <= 1'b1;
    #1;
    wait_ready(1'b1, CAL_N + 20);
    check("power-on cal length", 32'(n >= CAL_N && n <= CAL_N + 3), 32'h1);
    reg_read(`PAC_OFF_STATUS);
    check("status after cal", v, 32'h1);
    reg_read(`PAC_OFF_STATUS);
    check("status cleared", v, 32'h0);
    reg_read(`PAC_OFF_MASK);
    check("mask reset", v, 32'h0);
    reg_write(`PAC_OFF_MASK, 32'hFFFF_FFFF);
    reg_read(`PAC_OFF_MASK);
    check("mask width", v, 32'h7);
    reg_read(4'h2);
    check("unmapped read", v, 32'h0);
    reg_write(`PAC_OFF_MASK, 32'h1);
    $display("test reset and registers done");

    // Two words back to back; stored weights are 0x100 each.
    @(posedge clk_in);
    u_pac_host_model.set_raw(15'h0007);
    @(posedge clk_in);
    u_pac_host_model.set_raw(15'h7FFF);
    @(posedge clk_in);
    u_pac_host_model.set_raw(15'h0000);
    n = 1;
    #1;
    while (result !== 12'h300 && n < 30) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check("latency", 32'(n), 32'(LAT));
    @(posedge clk_in);
    #1;
    check("next word", 32'(result), 32'hF00);
    $display("test latency done");

    @(posedge clk_in);
    u_pac_host_model.set_oe_n(1'b1);
    repeat (4) @(posedge clk_in);
    #1;
    check("oe_n off", 32'(oe_n_o), 32'h1);
    check("pins float", 32'(result_pin === 12'hZZZ), 32'h1);
    @(posedge clk_in);
    u_pac_host_model.set_oe_n(1'b0);
    repeat (4) @(posedge clk_in);
    #1;
    check("pins driven", 32'(result_pin === result && oe_n_o === 1'b0), 32'h1);
    $display("test output enable done");

    @(posedge clk_in);
    u_pac_host_model.pulse_cal(2);
    repeat (8) @(posedge clk_in);
    #1;
    check("short cal ignored", 32'(ready), 32'h1);
    @(posedge clk_in);
    u_pac_host_model.set_weight(14'h0200);
    u_pac_host_model.pulse_cal(3);
    #1;
    wait_ready(1'b0, 8);
    check("cal ready fall", 32'(n <= 4), 32'h1);
    wait_ready(1'b1, CAL_N + 10);
    check("cal length", 32'(n), 32'(CAL_N));
    repeat (2) @(posedge clk_in);
    #1;
    check("irq raised", 32'(irq), 32'h1);
    reg_read(`PAC_OFF_STATUS);
    check("cal done bit", v, 32'h1);
    repeat (2) @(posedge clk_in);
    #1;
    check("irq cleared", 32'(irq), 32'h0);
    @(posedge clk_in);
    u_pac_host_model.set_raw(15'h7FFF);
    repeat (LAT + 2) @(posedge clk_in);
    #1;
    check("saturated code", 32'(result), 32'hFFF);
    @(posedge clk_in);
    u_pac_host_model.set_raw(15'h0001);
    repeat (LAT + 2) @(posedge clk_in);
    #1;
    check("new weight", 32'(result), 32'h200);
    $display("test calibration done");

    @(posedge clk_in);
    u_pac_host_model.set_pd(1'b1);
    #1;
    wait_ready(1'b0, 10);
    check("pd ready fall", 32'(n <= 7), 32'h1);
    // Words that change while ready is low must not reach the host's kept word.
    @(posedge clk_in);
    u_pac_host_model.set_raw(15'h7FFF);
    repeat (20) @(posedge clk_in);
    #1;
    check("low power held", 32'({low_power, ready}), 32'h2);
    check("kept word", 32'(u_pac_host_model.kept_q), 32'h200);
    @(posedge clk_in);
    u_pac_host_model.set_pd(1'b0);
    #1;
    wait_ready(1'b1, PDX_N + 10);
    check("pd exit length", 32'(n >= PDX_N && n <= PDX_N + 4), 32'h1);
    check("low power off", 32'(low_power), 32'h0);
    reg_read(`PAC_OFF_STATUS);
    check("pd status", v, 32'h6);
    check("irq masked", 32'(irq), 32'h0);
    $display("test power-down done");

    reg_write(`PAC_OFF_CTRL, 32'h1);
    #1;
    wait_ready(1'b0, 5);
    check("ctrl cal fall", 32'(n <= 3), 32'h1);
    reg_read(`PAC_OFF_STATE);
    check("state cal", v & 32'h7, 32'(PAC_CAL));
    wait_ready(1'b1, CAL_N + 10);
    reg_read(`PAC_OFF_STATE);
    check("state run", v & 32'h7, 32'h4 | 32'(PAC_RUN));
    $display("test register calibration done");
    results();
  end
endmodule : test_pipelined_adc_control_timing

`default_nettype wire
